// *** hw/dam_pkg.sv ***
`default_nettype none
package dam_pkg;
  // ****************************************
  // register map (16-bit words, 5-bit address)
  // ****************************************
  localparam logic [4:0]  A_PROD_SEL   = 5'h00;
  localparam logic [4:0]  A_OUT_FMT    = 5'h01;
  localparam logic [4:0]  A_ITEM_SEL0  = 5'h02;
  localparam logic [4:0]  A_SUBIDX0    = 5'h0C;
  localparam logic [4:0]  A_IRQ_STAT   = 5'h11;
  localparam logic [4:0]  A_IRQ_MASK   = 5'h12;
  localparam logic [4:0]  A_CMD_STATE  = 5'h13;
  localparam int          NUM_ITEMS    = 10;
  localparam int          NUM_SUB      = 5;
  localparam logic [15:0] SEL_NONE     = 16'h270F;
  localparam logic [15:0] SEL_MAX      = 16'h0FFF;
  localparam logic [15:0] OUT_FMT_RST  = 16'h0015;
  localparam logic [1:0]  PROD_SEL_RST = 2'h0;
  // ****************************************
  // assembly instances and objects
  // ****************************************
  localparam logic [1:0]  PS_BASIC     = 2'h0;
  localparam logic [1:0]  PS_EXT       = 2'h1;
  localparam logic [1:0]  PS_TRQ       = 2'h2;
  localparam logic [1:0]  PS_EXT_TRQ   = 2'h3;
  localparam logic [15:0] OUT_BASIC    = 16'h0014;
  localparam logic [15:0] OUT_EXT      = 16'h0015;
  localparam logic [15:0] OUT_TRQ      = 16'h0016;
  localparam logic [15:0] OUT_EXT_TRQ  = 16'h0017;
  localparam logic [2:0]  LEN_SHORT    = 3'h4;
  localparam logic [2:0]  LEN_LONG     = 3'h6;
  localparam logic [7:0]  CLS_CSUP     = 8'h29;
  localparam logic [7:0]  CLS_DRIVE    = 8'h2A;
  localparam logic [7:0]  CLS_PARAM    = 8'h00;
  localparam logic [7:0]  AT_RUN_REV   = 8'h04;
  localparam logic [7:0]  AT_RUN_FWD   = 8'h03;
  localparam logic [7:0]  AT_FLT_CLR   = 8'h0C;
  localparam logic [7:0]  AT_NET_CTRL  = 8'h05;
  localparam logic [7:0]  AT_NET_REF   = 8'h04;
  localparam logic [7:0]  AT_SPEED     = 8'h08;
  localparam logic [7:0]  AT_TORQUE    = 8'h0C;
  localparam int          B_RUN_FWD    = 0;
  localparam int          B_RUN_REV    = 1;
  localparam int          B_FLT_CLR    = 2;
  localparam int          B_NET_CTRL   = 5;
  localparam int          B_NET_REF    = 6;
  localparam int          IRQ_FRAME    = 0;
  localparam int          IRQ_PROD     = 1;
  localparam int          IRQ_DROP     = 2;
  localparam int          IRQ_OVR      = 3;
  localparam int          NUM_STEPS    = 17;
  localparam logic [4:0]  STEP_ITEM0   = 5'h07;
  localparam logic [4:0]  STEP_LAST    = 5'h10;
endpackage
`default_nettype wire

// *** hw/dam_cmd_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// one consumed frame handed from the parser to the dispatcher
interface dam_cmd_if;
  logic                    go;
  logic                    busy;
  logic [16:0]             en;
  logic [7:0]              cmd;
  logic [15:0]             speed;
  logic [15:0]             torque;
  logic [9:0][15:0]        val;
  logic [9:0][15:0]        sel;
  logic [9:0][7:0]         sub;
  modport src (output go, en, cmd, speed, torque, val, sel, sub, input busy);
  modport dst (input go, en, cmd, speed, torque, val, sel, sub, output busy);
endinterface
`default_nettype wire

// *** hw/dam_dispatch.sv ***
`timescale 1ns/1ps
`default_nettype none
module dam_dispatch (
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  dam_cmd_if.dst           cif,
  output logic             attr_wr_out,
  output logic [7:0]       attr_class_out,
  output logic [15:0]      attr_index_out,
  output logic [7:0]       attr_id_out,
  output logic [15:0]      attr_data_out
);
  import dam_pkg::*;
  typedef enum logic {DS_IDLE, DS_RUN} dam_disp_st_t;
  dam_disp_st_t     st;
  logic [4:0]       step;
  logic [3:0]       k;
  logic [16:0]      en;
  logic [7:0]       cmd;
  logic [15:0]      spd;
  logic [15:0]      trq;
  logic [9:0][15:0] val;
  logic [9:0][15:0] sel;
  logic [9:0][7:0]  sub;
  assign cif.busy = (st == DS_RUN);
  assign k = 4'(step - STEP_ITEM0);
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      st   <= DS_IDLE;
      step <= 5'h00;
    end else begin
      unique case (st)
        DS_IDLE: if (cif.go) begin
          st   <= DS_RUN;
          step <= 5'h00;
        end
        DS_RUN: begin
          step <= step + 5'h01;
          if (step == STEP_LAST) st <= DS_IDLE;
        end
      endcase
    end
  end
  // snapshot so a following frame cannot tear the writes in flight
  always_ff @(posedge mclk_in) begin
    if (cif.go && st == DS_IDLE) begin
      en  <= cif.en;
      cmd <= cif.cmd;
      spd <= cif.speed;
      trq <= cif.torque;
      val <= cif.val;
      sel <= cif.sel;
      sub <= cif.sub;
    end
  end
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      attr_wr_out    <= 1'b0;
      attr_class_out <= 8'h00;
      attr_index_out <= 16'h0000;
      attr_id_out    <= 8'h00;
      attr_data_out  <= 16'h0000;
    end else begin
      attr_wr_out    <= (st == DS_RUN) && en[step];
      attr_class_out <= CLS_CSUP;
      attr_index_out <= 16'h0001;
      attr_data_out  <= 16'h0000;
      unique case (step)
        5'h00: begin attr_id_out <= AT_RUN_REV; attr_data_out[0] <= cmd[B_RUN_REV]; end // [RQ7]
        5'h01: begin attr_id_out <= AT_RUN_FWD; attr_data_out[0] <= cmd[B_RUN_FWD]; end // [RQ7]
        5'h02: begin attr_id_out <= AT_FLT_CLR; attr_data_out[0] <= cmd[B_FLT_CLR]; end // [RQ7]
        5'h03: begin attr_id_out <= AT_NET_CTRL; attr_data_out[0] <= cmd[B_NET_CTRL]; end // [RQ7]
        5'h04: begin
          attr_class_out   <= CLS_DRIVE; // [RQ8]
          attr_id_out      <= AT_NET_REF;
          attr_data_out[0] <= cmd[B_NET_REF];
        end
        5'h05: begin attr_class_out <= CLS_DRIVE; attr_id_out <= AT_SPEED; attr_data_out <= spd; end // [RQ8]
        5'h06: begin attr_class_out <= CLS_DRIVE; attr_id_out <= AT_TORQUE; attr_data_out <= trq; end // [RQ8]
        default: begin
          attr_class_out <= CLS_PARAM;
          attr_index_out <= (k < 4'(NUM_ITEMS)) ? sel[k] : 16'h0000;
          attr_id_out    <= (k < 4'(NUM_ITEMS)) ? sub[k] : 8'h00;
          attr_data_out  <= (k < 4'(NUM_ITEMS)) ? val[k] : 16'h0000;
        end
      endcase
    end
  end
  // ****************************************
  // checks
  // ****************************************
  sequence s_start;
    cif.go && !cif.busy;
  endsequence
  property p_run_fwd;
    @(posedge mclk_in) disable iff (!rstn_in)
    s_start ##0 cif.en[1] |-> ##3 attr_wr_out && attr_class_out == CLS_CSUP
      && attr_id_out == AT_RUN_FWD && attr_data_out[0] == $past(cif.cmd[B_RUN_FWD], 3);
  endproperty
  a_run_fwd: assert property (p_run_fwd) else $error("run forward not routed"); // [RQ7]
  property p_speed;
    @(posedge mclk_in) disable iff (!rstn_in)
    s_start ##0 cif.en[5] |-> ##7 attr_wr_out && attr_class_out == CLS_DRIVE
      && attr_id_out == AT_SPEED && attr_data_out == $past(cif.speed, 7);
  endproperty
  a_speed: assert property (p_speed) else $error("speed setpoint not routed"); // [RQ8]
  property p_torque;
    @(posedge mclk_in) disable iff (!rstn_in)
    s_start ##0 cif.en[6] |-> ##8 attr_wr_out && attr_class_out == CLS_DRIVE
      && attr_id_out == AT_TORQUE && attr_data_out == $past(cif.torque, 8);
  endproperty
  a_torque: assert property (p_torque) else $error("torque setpoint not routed"); // [RQ8]
endmodule
`default_nettype wire

// *** hw/dam_mapper.sv ***
// Design decisions made here: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// [RQ1] basic status image: four bytes, run and fault
// [RQ2] extended status image: eight flags, state, speed
// [RQ3] speed and torque image: basic plus torque
// [RQ4] extended image plus torque, six bytes
// [RQ5] fixed block first, user items from n
// [RQ6] item subindex from lower/upper setting byte
// [RQ7] command bits go to supervisor attributes
// [RQ8] reference and setpoints go to drive attributes
// [RQ9] 9999 item is empty; unknown item unwritten
// [RQ10] each produced image is one consistent sample
module dam_mapper (
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic [4:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic [15:0]      reg_rdata_out,
  output logic             irq_out,
  input  wire logic        faulted_in,
  input  wire logic        warning_in,
  input  wire logic        run_fwd_in,
  input  wire logic        run_rev_in,
  input  wire logic        ready_in,
  input  wire logic        ctrl_from_net_in,
  input  wire logic        ref_from_net_in,
  input  wire logic        at_reference_in,
  input  wire logic [7:0]  drive_state_in,
  input  wire logic [15:0] speed_actual_in,
  input  wire logic [15:0] torque_actual_in,
  input  wire logic        produce_req_in,
  output logic [47:0]      tx_image_out,
  output logic [2:0]       tx_len_out,
  output logic             tx_valid_out,
  input  wire logic        rx_valid_in,
  input  wire logic        rx_sof_in,
  input  wire logic        rx_eof_in,
  input  wire logic [7:0]  rx_byte_in,
  output logic             attr_wr_out,
  output logic [7:0]       attr_class_out,
  output logic [15:0]      attr_index_out,
  output logic [7:0]       attr_id_out,
  output logic [15:0]      attr_data_out
);
  import dam_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [2:0] fmt_len(input logic [15:0] f);
    logic [2:0] r;
    r = 3'h0;
    if (f == OUT_BASIC || f == OUT_EXT) r = LEN_SHORT;
    if (f == OUT_TRQ || f == OUT_EXT_TRQ) r = LEN_LONG;
    return r;
  endfunction

  // a repeated selector counts as empty behind its first use
  function automatic logic item_skip(input logic [9:0][15:0] s,
                                     input int k);
    logic r;
    r = (s[k] == SEL_NONE);
    for (int j = 0; j < NUM_ITEMS; j++) begin
      if (j < k && s[j] == s[k]) r = 1'b1;
    end
    return r;
  endfunction

  function automatic logic [3:0] next_item(input logic [9:0][15:0] s,
                                           input int from);
    logic [3:0] r;
    r = 4'(NUM_ITEMS);
    for (int j = NUM_ITEMS - 1; j >= 0; j--) begin
      if (j >= from && !item_skip(s, j)) r = 4'(j);
    end
    return r;
  endfunction

  // ****************************************
  // registers
  // ****************************************
  logic [1:0]       prod_sel;
  logic [15:0]      out_fmt;
  logic [9:0][15:0] item_sel;
  logic [4:0][15:0] sub_set;
  logic [3:0]       irq_stat;
  logic [3:0]       irq_mask;
  logic [3:0]       irq_ev;
  logic [3:0]       irq_clr;
  logic [15:0]      next_rdata;
  logic [7:0]       cmd_seen;

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      prod_sel <= PROD_SEL_RST;
      out_fmt  <= OUT_FMT_RST;
      item_sel <= {NUM_ITEMS{SEL_NONE}};
      sub_set  <= '0;
      irq_mask <= 4'h0;
    end else if (reg_wr_in) begin
      if (reg_addr_in == A_PROD_SEL) prod_sel <= reg_wdata_in[1:0];
      if (reg_addr_in == A_OUT_FMT) out_fmt <= reg_wdata_in;
      if (reg_addr_in == A_IRQ_MASK) irq_mask <= reg_wdata_in[3:0];
      for (int i = 0; i < NUM_ITEMS; i++) begin
        if (reg_addr_in == A_ITEM_SEL0 + 5'(i)) item_sel[i] <= reg_wdata_in;
      end
      for (int i = 0; i < NUM_SUB; i++) begin
        if (reg_addr_in == A_SUBIDX0 + 5'(i)) sub_set[i] <= reg_wdata_in;
      end
    end
  end

  // write-one-to-clear; a new event in the same cycle wins
  assign irq_clr = (reg_wr_in && reg_addr_in == A_IRQ_STAT) ? reg_wdata_in[3:0] : 4'h0;

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) irq_stat <= 4'h0;
    else irq_stat <= (irq_stat & ~irq_clr) | irq_ev;
  end

  assign irq_out = |(irq_stat & irq_mask);

  always_comb begin
    next_rdata = 16'h0000;
    if (reg_rd_in) begin
      if (reg_addr_in == A_PROD_SEL) next_rdata = {14'h0000, prod_sel};
      if (reg_addr_in == A_OUT_FMT) next_rdata = out_fmt;
      if (reg_addr_in == A_IRQ_STAT) next_rdata = {12'h000, irq_stat};
      if (reg_addr_in == A_IRQ_MASK) next_rdata = {12'h000, irq_mask};
      if (reg_addr_in == A_CMD_STATE) next_rdata = {8'h00, cmd_seen};
      for (int i = 0; i < NUM_ITEMS; i++) begin
        if (reg_addr_in == A_ITEM_SEL0 + 5'(i)) next_rdata = item_sel[i];
      end
      for (int i = 0; i < NUM_SUB; i++) begin
        if (reg_addr_in == A_SUBIDX0 + 5'(i)) next_rdata = sub_set[i];
      end
    end
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) reg_rdata_out <= 16'h0000;
    else reg_rdata_out <= next_rdata;
  end

  // ****************************************
  // producing side
  // ****************************************
  logic [7:0]  basic_flags;
  logic [7:0]  ext_flags;
  logic [47:0] next_img;
  logic        prod_ext;
  logic        prod_trq;

  assign prod_ext = prod_sel[0];
  assign prod_trq = prod_sel[1];
  assign basic_flags = {5'h00, run_fwd_in, 1'b0, faulted_in}; // [RQ1]
  assign ext_flags = {at_reference_in, ref_from_net_in, ctrl_from_net_in, ready_in,
                      run_rev_in, run_fwd_in, warning_in, faulted_in}; // [RQ2]

  always_comb begin
    next_img[7:0]   = prod_ext ? ext_flags : basic_flags; // [RQ3] [RQ4]
    next_img[15:8]  = prod_ext ? drive_state_in : 8'h00; // [RQ2]
    next_img[31:16] = speed_actual_in; // [RQ1]
    next_img[47:32] = prod_trq ? torque_actual_in : 16'h0000; // [RQ3]
  end

  // all bytes taken on the same edge, so no frame mixes two samples
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      tx_valid_out <= 1'b0;
      tx_image_out <= 48'h000000000000;
      tx_len_out   <= LEN_SHORT;
    end else begin
      tx_valid_out <= produce_req_in;
      if (produce_req_in) begin
        tx_image_out <= next_img; // [RQ10]
        tx_len_out   <= prod_trq ? LEN_LONG : LEN_SHORT; // [RQ4]
      end
    end
  end

  // ****************************************
  // consuming side
  // ****************************************
  dam_cmd_if cif ();

  logic [2:0]       nlen;
  logic [4:0]       nlen5;
  logic [4:0]       pos;
  logic [4:0]       cur_pos;
  logic [3:0]       item_idx;
  logic [3:0]       cur_idx;
  logic             half;
  logic             cur_half;
  logic             in_user;
  logic [5:0][7:0]  fix_buf;
  logic [9:0][15:0] item_val;
  logic [9:0]       item_got;
  logic [9:0]       exists;
  logic             frame_done;

  assign nlen = fmt_len(out_fmt);
  assign nlen5 = {2'h0, nlen};
  assign cur_pos = rx_sof_in ? 5'h00 : pos;
  assign cur_idx = rx_sof_in ? next_item(item_sel, 0) : item_idx; // [RQ9]
  assign cur_half = rx_sof_in ? 1'b0 : half;
  assign in_user = cur_pos >= nlen5 && cur_idx < 4'(NUM_ITEMS); // [RQ5]

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      pos      <= 5'h00;
      item_idx <= 4'h0;
      half     <= 1'b0;
      item_got <= 10'h000;
    end else if (rx_valid_in) begin
      if (cur_pos != 5'h1F) pos <= cur_pos + 5'h01;
      if (rx_sof_in) item_got <= 10'h000;
      if (in_user && cur_half) begin
        item_got[cur_idx] <= 1'b1;
        item_idx <= next_item(item_sel, int'(cur_idx) + 1); // [RQ9]
        half     <= 1'b0;
      end else begin
        item_idx <= cur_idx;
        half     <= cur_half ^ in_user;
      end
    end
  end

  // data bytes carry no reset; the valid bits guard them
  always_ff @(posedge mclk_in) begin
    if (rx_valid_in && cur_pos < nlen5) fix_buf[cur_pos[2:0]] <= rx_byte_in; // [RQ5]
    if (rx_valid_in && in_user) begin
      if (cur_half) item_val[cur_idx][15:8] <= rx_byte_in;
      else item_val[cur_idx][7:0] <= rx_byte_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      frame_done <= 1'b0;
      cmd_seen   <= 8'h00;
    end else begin
      frame_done <= rx_valid_in && rx_eof_in;
      if (frame_done && nlen != 3'h0) cmd_seen <= fix_buf[0];
    end
  end

  for (genvar k = 0; k < NUM_ITEMS; k++) begin : g_item
    assign exists[k] = item_sel[k] <= SEL_MAX; // [RQ9]
    assign cif.sub[k] = (k % 2 == 1) ? sub_set[k / 2][15:8] : sub_set[k / 2][7:0]; // [RQ6]
  end

  assign cif.go = frame_done && !cif.busy;
  assign cif.cmd = fix_buf[0];
  assign cif.speed = {fix_buf[3], fix_buf[2]};
  assign cif.torque = {fix_buf[5], fix_buf[4]};
  assign cif.val = item_val;
  assign cif.sel = item_sel;
  assign cif.en[1] = nlen != 3'h0; // [RQ7]
  assign cif.en[2] = nlen != 3'h0;
  assign cif.en[5] = nlen != 3'h0; // [RQ8]
  assign cif.en[0] = out_fmt == OUT_EXT || out_fmt == OUT_EXT_TRQ;
  assign cif.en[3] = cif.en[0];
  assign cif.en[4] = cif.en[0];
  assign cif.en[6] = nlen == LEN_LONG;
  assign cif.en[16:7] = item_got & exists; // [RQ9]

  assign irq_ev[IRQ_FRAME] = frame_done;
  assign irq_ev[IRQ_PROD] = produce_req_in;
  assign irq_ev[IRQ_DROP] = frame_done && |(item_got & ~exists);
  assign irq_ev[IRQ_OVR] = frame_done && cif.busy;

  dam_dispatch u_dispatch (
    .mclk_in        (mclk_in),
    .rstn_in        (rstn_in),
    .cif            (cif),
    .attr_wr_out    (attr_wr_out),
    .attr_class_out (attr_class_out),
    .attr_index_out (attr_index_out),
    .attr_id_out    (attr_id_out),
    .attr_data_out  (attr_data_out)
  );

  // ****************************************
  // checks
  // ****************************************
  property p_basic;
    @(posedge mclk_in) disable iff (!rstn_in)
    produce_req_in && prod_sel == PS_BASIC |=> tx_len_out == LEN_SHORT
      && tx_image_out[7:0] == {5'h00, $past(run_fwd_in), 1'b0, $past(faulted_in)}
      && tx_image_out[15:8] == 8'h00 && tx_image_out[31:16] == $past(speed_actual_in);
  endproperty
  a_basic: assert property (p_basic) else $error("basic status image wrong"); // [RQ1]

  property p_ext;
    @(posedge mclk_in) disable iff (!rstn_in)
    produce_req_in && prod_sel == PS_EXT |=> tx_len_out == LEN_SHORT
      && tx_image_out[15:8] == $past(drive_state_in) && tx_image_out[7] == $past(at_reference_in)
      && tx_image_out[3] == $past(run_rev_in) && tx_image_out[1] == $past(warning_in);
  endproperty
  a_ext: assert property (p_ext) else $error("extended status image wrong"); // [RQ2]

  property p_trq;
    @(posedge mclk_in) disable iff (!rstn_in)
    produce_req_in && prod_sel == PS_TRQ |=> tx_len_out == LEN_LONG
      && tx_image_out[15:8] == 8'h00 && tx_image_out[47:32] == $past(torque_actual_in)
      && tx_image_out[7:3] == 5'h00;
  endproperty
  a_trq: assert property (p_trq) else $error("speed and torque image wrong"); // [RQ3]

  property p_ext_trq;
    @(posedge mclk_in) disable iff (!rstn_in)
    produce_req_in && prod_sel == PS_EXT_TRQ |=> tx_len_out == LEN_LONG
      && tx_image_out[15:8] == $past(drive_state_in)
      && tx_image_out[47:16] == {$past(torque_actual_in), $past(speed_actual_in)};
  endproperty
  a_ext_trq: assert property (p_ext_trq) else $error("extended torque image wrong"); // [RQ4]

  property p_hold;
    @(posedge mclk_in) disable iff (!rstn_in)
    !produce_req_in |=> $stable(tx_image_out) && !tx_valid_out;
  endproperty
  a_hold: assert property (p_hold) else $error("image changed between productions"); // [RQ10]

  property p_first_item;
    @(posedge mclk_in) disable iff (!rstn_in)
    rx_valid_in && cur_pos == nlen5 && in_user
      |=> half && item_val[item_idx][7:0] == $past(rx_byte_in);
  endproperty
  a_first_item: assert property (p_first_item) else $error("user item not at offset n"); // [RQ5]

  property p_sub;
    @(posedge mclk_in) disable iff (!rstn_in)
    reg_wr_in && reg_addr_in == A_SUBIDX0 + 5'h04
      |=> cif.sub[9] == $past(reg_wdata_in[15:8]) && cif.sub[8] == $past(reg_wdata_in[7:0]);
  endproperty
  a_sub: assert property (p_sub) else $error("subindex byte mapping wrong"); // [RQ6]

  property p_no_write;
    @(posedge mclk_in) disable iff (!rstn_in)
    cif.go |-> (cif.en[16:7] & ~exists) == 10'h000;
  endproperty
  a_no_write: assert property (p_no_write) else $error("unknown item dispatched"); // [RQ9]

  property p_drop_flag;
    @(posedge mclk_in) disable iff (!rstn_in)
    frame_done && |(item_got & ~exists) |=> irq_stat[IRQ_DROP];
  endproperty
  a_drop_flag: assert property (p_drop_flag) else $error("dropped item not flagged"); // [RQ9]
endmodule
`default_nettype wire

// *** dv/dam_scanner_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// scanner side of the cyclic exchange
// ****
module dam_scanner_model (
  input  wire logic  mclk_in,
  output logic       prod_out,
  output logic       valid_out,
  output logic       sof_out,
  output logic       eof_out,
  output logic [7:0] byte_out
);
  initial begin
    prod_out  = 1'b0;
    valid_out = 1'b0;
    sof_out   = 1'b0;
    eof_out   = 1'b0;
    byte_out  = 8'hA5;
  end
  task automatic produce();
    @(posedge mclk_in) prod_out <= 1'b1;
    @(posedge mclk_in) prod_out <= 1'b0;
  endtask
  // idle lane inverts between bytes so a stale byte never looks valid
  task automatic send(input logic [7:0] b[$], input int gap);
    for (int i = 0; i < b.size(); i++) begin
      repeat (i > 0 ? gap : 0) @(posedge mclk_in) begin
        valid_out <= 1'b0;
        byte_out  <= ~byte_out;
      end
      @(posedge mclk_in);
      valid_out <= 1'b1;
      sof_out   <= (i == 0);
      eof_out   <= (i == b.size() - 1);
      byte_out  <= b[i];
    end
    @(posedge mclk_in);
    valid_out <= 1'b0;
    eof_out   <= 1'b0;
    byte_out  <= ~byte_out;
  endtask
endmodule
`default_nettype wire

// *** dv/drive_assembly_io_mapper_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****
// bench: register map, produced images, consumed frames, irq
// ****
module drive_assembly_io_mapper_tb_top;
  import dam_pkg::*;
  logic        mclk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic [4:0]  addr    = 5'h00;
  logic [15:0] wdata   = 16'h0000;
  logic        wr      = 1'b0;
  logic        rd      = 1'b0;
  logic [7:0]  fl      = 8'h00;
  logic [7:0]  st      = 8'h00;
  logic [15:0] spd     = 16'h0000;
  logic [15:0] trq     = 16'h0000;
  logic [15:0] lf      = 16'h1CE2;
  logic [15:0] rdata, ax, ad;
  logic [47:0] img;
  logic [2:0]  len;
  logic [7:0]  ac, aid, rb;
  logic        irq, txv, aw, prq, rv, rs, re;
  logic [47:0] seen[$];
  logic [47:0] expq[$];
  int          errors   = 0;
  int          compares = 0;
  always #50 mclk_in = ~mclk_in;
  always @(posedge mclk_in) if (aw === 1'b1) seen.push_back({ac, ax, aid, ad});
  dam_scanner_model SCN (.mclk_in(mclk_in), .prod_out(prq), .valid_out(rv), .sof_out(rs),
    .eof_out(re), .byte_out(rb));
  dam_mapper DUT (.mclk_in(mclk_in), .rstn_in(rstn_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .irq_out(irq), .faulted_in(fl[0]), .warning_in(fl[1]), .run_fwd_in(fl[2]),
    .run_rev_in(fl[3]), .ready_in(fl[4]), .ctrl_from_net_in(fl[5]), .ref_from_net_in(fl[6]),
    .at_reference_in(fl[7]), .drive_state_in(st), .speed_actual_in(spd),
    .torque_actual_in(trq), .produce_req_in(prq), .tx_image_out(img), .tx_len_out(len),
    .tx_valid_out(txv), .rx_valid_in(rv), .rx_sof_in(rs), .rx_eof_in(re), .rx_byte_in(rb),
    .attr_wr_out(aw), .attr_class_out(ac), .attr_index_out(ax), .attr_id_out(aid),
    .attr_data_out(ad));
  function automatic logic [15:0] nx(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  function automatic logic [47:0] exp_img(input logic [1:0] s, input logic [7:0] f, t,
                                          input logic [15:0] v, q);
    return {s[1] ? q : 16'h0000, v, s[0] ? t : 8'h00,
            s[0] ? f : {5'h00, f[2], 1'h0, f[0]}};
  endfunction
  function automatic logic [47:0] cw(input logic [7:0] c, i, input logic b);
    return {c, 16'h0001, i, 15'h0000, b};
  endfunction
  task automatic check(input logic [47:0] sv, ev, input string what);
    compares++;
    if (sv !== ev) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, ev, sv);
    end
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge mclk_in);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge mclk_in) wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] v);
    @(posedge mclk_in);
    addr <= a;
    rd   <= 1'b1;
    @(posedge mclk_in) rd <= 1'b0;
    #1 v = rdata;
  endtask
  task automatic frame(input logic [15:0] fmt, sel, sub, input int gap);
    logic [7:0]  c;
    logic [15:0] v, q, i1, i2;
    logic [7:0]  b[$];
    c  = lf[7:0];
    v  = nx(lf);
    q  = nx(v);
    i1 = nx(q);
    i2 = nx(i1);
    lf = nx(i2);
    wr_reg(A_OUT_FMT, fmt);
    wr_reg(A_ITEM_SEL0, sel);
    wr_reg(A_ITEM_SEL0 + 5'h01, sel + 16'h0001);
    wr_reg(A_SUBIDX0, sub);
    b = {c, 8'h00, v[7:0], v[15:8]};
    expq = {};
    if (fmt[0]) expq.push_back(cw(CLS_CSUP, AT_RUN_REV, c[B_RUN_REV]));
    expq.push_back(cw(CLS_CSUP, AT_RUN_FWD, c[B_RUN_FWD]));
    expq.push_back(cw(CLS_CSUP, AT_FLT_CLR, c[B_FLT_CLR]));
    if (fmt[0]) begin
      expq.push_back(cw(CLS_CSUP, AT_NET_CTRL, c[B_NET_CTRL]));
      expq.push_back(cw(CLS_DRIVE, AT_NET_REF, c[B_NET_REF]));
    end
    expq.push_back({CLS_DRIVE, 16'h0001, AT_SPEED, v});
    if (fmt[1]) begin
      b = {b, q[7:0], q[15:8]};
      expq.push_back({CLS_DRIVE, 16'h0001, AT_TORQUE, q});
    end
    b = {b, i1[7:0], i1[15:8], i2[7:0], i2[15:8]};
    if (sel <= SEL_MAX) begin
      expq.push_back({CLS_PARAM, sel, sub[7:0], i1});
      expq.push_back({CLS_PARAM, sel + 16'h0001, sub[15:8], i2});
    end
    seen = {};
    SCN.send(b, gap);
    repeat (25) @(posedge mclk_in);
    check(48'(seen.size()), 48'(expq.size()), "attr count");
    foreach (expq[k]) check(seen[k], expq[k], "attr write");
    $display("test frame %h done", fmt);
  endtask
  task automatic test_done();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    #(100 * 4000);
    errors++;
    test_done();
  end
  initial begin
    logic [15:0] v;
    logic [47:0] e;
    repeat (6) @(posedge mclk_in);
    rstn_in <= 1'b1;
    rd_reg(A_OUT_FMT, v);
    check(48'(v), 48'(OUT_FMT_RST), "out fmt");
    for (int i = 0; i < NUM_ITEMS; i++) begin
      rd_reg(A_ITEM_SEL0 + 5'(i), v);
      check(48'(v), 48'(SEL_NONE), "item sel");
    end
    rd_reg(5'h1F, v);
    check(48'(v), 48'h0, "unmapped");
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      wr_reg(A_PROD_SEL, 16'(i % 4));
      @(posedge mclk_in);
      fl  <= lf[7:0];
      st  <= lf[15:8];
      spd <= nx(lf);
      trq <= nx(nx(lf));
      lf = nx(nx(nx(lf)));
      SCN.produce();
      #1 e = exp_img(2'(i), fl, st, spd, trq);
      check(48'(txv), 48'h1, "tx valid");
      check(img, e, "image");
      check(48'(len), 48'((i % 4) > 1 ? LEN_LONG : LEN_SHORT), "len");
      @(posedge mclk_in) fl <= ~fl;
      @(posedge mclk_in);
      #1 check(img, e, "image held");
    end
    $display("test produce done");
    wr_reg(A_IRQ_MASK, 16'h0004);
    frame(OUT_EXT_TRQ, 16'h0005, 16'hAB12, 0);
    check(48'(irq), 48'h0, "irq masked");
    frame(OUT_BASIC, 16'h1000, 16'h3456, 2);
    check(48'(irq), 48'h1, "irq drop");
    rd_reg(A_IRQ_STAT, v);
    check(48'(v), 48'h0007, "irq stat");
    wr_reg(A_IRQ_STAT, 16'h000F);
    #1 check(48'(irq), 48'h0, "irq clear");
    $display("test irq done");
    test_done();
  end
endmodule
`default_nettype wire
